/* verilog/tdm_monitor.sv */
// discrepancy monitor for a triple-redundant controller
// Overview of operation
// - discrete inputs from buses a, b, c are voted two out of three
// - each copy differing from the voted value raises its own flag
// - any discrete or analog discrepancy sets that input's fault contact
// - an input discrepancy reports only after lasting the filter time
// - discrepancy faults stay latched until a fault reset
// - checks cover discrete inputs, discrete outputs, analog inputs only
// - output blocks are polled; answer names output and controller
// - controller output data differing from voted state sets fault bits
// - output checks start only while no autotest is in progress; one in the window aborts them
// - redundant output blocks, or enabled non-redundant ones, are checked
// - output change during a check retries it, three attempts at most
// - fast toggling outputs discard the result and log incomplete check
// - incomplete check message gives rack, slot and bus position
// - analog threshold band is a percentage of the voted value
// - analog voted value is the median of three readings
// - analog limit band is a percentage of full scale
// - analog channel discrepant only when both bands are exceeded
// - up to two analog channels may be discrepant at once
// - source tristate: off below 30%, on mid, short above supply-4V
// - sink tristate: short below 4V, on mid, off above 70%
// - logged faults carry codes f1, f3 and f4
module tdm_monitor
	import tdm_pkg::*;
#(
	parameter int NDI = 8,
	parameter int NDO = 8,
	parameter int AW  = 16
) (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// scan timing and global fault reset
	input  wire logic                   scan_pulse,
	input  wire logic                   fault_reset_req,
	input  wire logic [7:0]             filter_scans,
	// discrete inputs as received on each bus
	input  wire logic [NDI-1:0]         din_a,
	input  wire logic [NDI-1:0]         din_b,
	input  wire logic [NDI-1:0]         din_c,
	// discrete input results
	output logic      [NDI-1:0]         voted_din,
	output logic      [NDI-1:0]         di_disc_a,
	output logic      [NDI-1:0]         di_disc_b,
	output logic      [NDI-1:0]         di_disc_c,
	output logic      [NDI-1:0]         di_fault_contact,
	// analog input in engineering units and its bands
	input  wire logic [AW-1:0]          ain_a,
	input  wire logic [AW-1:0]          ain_b,
	input  wire logic [AW-1:0]          ain_c,
	input  wire logic [6:0]             thresh_pct,
	input  wire logic [6:0]             limit_pct,
	input  wire logic [AW-1:0]          full_scale,
	// analog input results
	output logic      [AW-1:0]          voted_ain,
	output logic      [2:0]             ai_disc,
	output logic                        ai_fault_contact,
	// output block under check
	input  wire logic                   autotest_busy,
	input  wire logic                   block_redundant,
	input  wire logic                   block_check_en,
	input  wire logic [7:0]             block_rack,
	input  wire logic [7:0]             block_slot,
	input  wire logic [4:0]             serial_bus_position,
	input  wire logic [NDO-1:0]         ctl_out_a,
	input  wire logic [NDO-1:0]         ctl_out_b,
	input  wire logic [NDO-1:0]         ctl_out_c,
	input  wire logic [NDO-1:0]         voted_dout,
	// poll of the block and its answer
	output logic                        poll_req,
	input  wire logic                   poll_ack,
	input  wire logic                   poll_disc,
	input  wire logic [$clog2(NDO)-1:0] poll_output,
	input  wire logic [1:0]             poll_ctl,
	// discrete output results
	output logic      [NDO-1:0]         do_disc_a,
	output logic      [NDO-1:0]         do_disc_b,
	output logic      [NDO-1:0]         do_disc_c,
	output logic      [NDO-1:0]         do_fault_contact,
	// incomplete check message
	output logic                        inc_valid,
	output logic      [7:0]             inc_rack,
	output logic      [7:0]             inc_slot,
	output logic      [4:0]             inc_position,
	// fault log event
	output logic                        log_valid,
	output logic      [7:0]             log_code,
	// tristate field input in redundancy mode
	input  wire logic                   tri_sink,
	input  wire logic [15:0]            tri_mv,
	input  wire logic [15:0]            supply_mv,
	output logic                        tri_value,
	output logic                        tri_on,
	output logic                        tri_short
);

	// fault reset acts at every scan while it is requested
	wire clear = fault_reset_req && scan_pulse;
	// discrete vote and raw per-copy mismatch
	wire [NDI-1:0] vote = (din_a & din_b) | (din_b & din_c)
		| (din_a & din_c);
	wire [NDI-1:0] raw_a = din_a ^ vote;
	wire [NDI-1:0] raw_b = din_b ^ vote;
	wire [NDI-1:0] raw_c = din_c ^ vote;
	// one filter per input per copy
	genvar gi;
	generate
		for (gi = 0; gi < NDI; gi++) begin : g_di
			tdm_filter u_fa (.clk(clk), .rst_n(rst_n),
				.scan_pulse(scan_pulse), .clear(clear),
				.filter_scans(filter_scans), .raw(raw_a[gi]),
				.latched(di_disc_a[gi]));
			tdm_filter u_fb (.clk(clk), .rst_n(rst_n),
				.scan_pulse(scan_pulse), .clear(clear),
				.filter_scans(filter_scans), .raw(raw_b[gi]),
				.latched(di_disc_b[gi]));
			tdm_filter u_fc (.clk(clk), .rst_n(rst_n),
				.scan_pulse(scan_pulse), .clear(clear),
				.filter_scans(filter_scans), .raw(raw_c[gi]),
				.latched(di_disc_c[gi]));
		end
	endgenerate
	assign di_fault_contact = di_disc_a | di_disc_b | di_disc_c;

	// analog median: the middle reading never deviates from itself,
	// so at most two channels can be newly flagged in one scan
	wire [AW-1:0] mn_ab = (ain_a < ain_b) ? ain_a : ain_b;
	wire [AW-1:0] mx_ab = (ain_a < ain_b) ? ain_b : ain_a;
	wire [AW-1:0] hi_c  = (mx_ab < ain_c) ? mx_ab : ain_c;
	wire [AW-1:0] med   = (mn_ab < hi_c) ? hi_c : mn_ab;
	wire [AW-1:0] ain [3];
	assign ain[0] = ain_a;
	assign ain[1] = ain_b;
	assign ain[2] = ain_c;
	// band checks in scaled percent, 32 bits covers 16-bit values
	wire [31:0] thr_lim = 32'(thresh_pct) * 32'(med);
	wire [31:0] fs_lim  = 32'(limit_pct) * 32'(full_scale);
	wire [2:0]  ai_raw;

	generate
		for (gi = 0; gi < 3; gi++) begin : g_ai
			wire [AW-1:0] dev = (ain[gi] > med) ? ain[gi] - med
				: med - ain[gi];
			wire [31:0] dev_s = 32'(dev) * PCT_SCALE;
			wire over_thr = dev_s > thr_lim;
			wire over_lim = dev_s > fs_lim;
			assign ai_raw[gi] = over_thr && over_lim;
			tdm_filter u_fa (.clk(clk), .rst_n(rst_n),
				.scan_pulse(scan_pulse), .clear(clear),
				.filter_scans(filter_scans), .raw(ai_raw[gi]),
				.latched(ai_disc[gi]));
		end
	endgenerate
	assign ai_fault_contact = |ai_disc;

	// voted values registered once per scan
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			voted_din <= '0;
			voted_ain <= '0;
		end else if (scan_pulse) begin
			voted_din <= vote;
			voted_ain <= med;
		end
	end

	// analog outputs get no monitor; only the three kinds above
	// ---------------- output discrepancy check ----------------
	tdm_state_type   state_reg, state_next;
	logic [NDO-1:0]  snap_reg;
	logic [3:0]      win_reg;
	logic [1:0]      att_reg;

	wire check_ok   = block_redundant || block_check_en;
	wire start      = scan_pulse && check_ok && !autotest_busy;
	wire moved      = voted_dout != snap_reg;
	wire last_try   = att_reg == MAX_ATTEMPTS;
	// window spans the ten scans an output must hold still
	wire win_end    = win_reg == CHECK_SCANS - 4'h1;
	wire run_scan   = (state_reg == ST_RUN) && scan_pulse;
	wire give_up    = run_scan && moved && last_try;
	wire retry      = run_scan && moved && !last_try;
	wire poll_take  = (state_reg == ST_POLL) && poll_ack;
	wire compare    = state_reg == ST_DONE;

	// sequence: poll block, watch a window, then compare
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE: if (start) state_next = ST_POLL;
			ST_POLL: if (poll_ack) state_next = ST_RUN;
			ST_RUN: begin
				if (autotest_busy || give_up)
					state_next = ST_IDLE;
				else if (run_scan && !moved && win_end)
					state_next = ST_DONE;
			end
			ST_DONE: state_next = ST_IDLE;
		endcase
	end

	assign poll_req = state_reg == ST_POLL;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			snap_reg  <= '0;
			win_reg   <= WIN_CNT_RST;
			att_reg   <= ATTEMPT_RST;
		end else begin
			state_reg <= state_next;
			if (state_reg == ST_IDLE && start) begin
				snap_reg <= voted_dout;
				win_reg  <= WIN_CNT_RST;
				att_reg  <= ATTEMPT_RST;
			end else if (retry) begin
				snap_reg <= voted_dout;
				win_reg  <= WIN_CNT_RST;
				att_reg  <= att_reg + 2'h1;
			end else if (run_scan) begin
				win_reg  <= win_reg + 4'h1;
			end
		end
	end

	// mismatch sources: the final compare and the block's own answer
	logic [NDO-1:0] pol_a, pol_b, pol_c;
	always_comb begin
		pol_a = '0;
		pol_b = '0;
		pol_c = '0;
		if (poll_take && poll_disc) begin
			pol_a[poll_output] = poll_ctl == 2'h0;
			pol_b[poll_output] = poll_ctl == 2'h1;
			pol_c[poll_output] = poll_ctl == 2'h2;
		end
	end

	wire [NDO-1:0] cmp_a = compare ? ctl_out_a ^ voted_dout : '0;
	wire [NDO-1:0] cmp_b = compare ? ctl_out_b ^ voted_dout : '0;
	wire [NDO-1:0] cmp_c = compare ? ctl_out_c ^ voted_dout : '0;
	// clear wins in its own cycle; a persisting mismatch re-latches
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			do_disc_a <= '0;
			do_disc_b <= '0;
			do_disc_c <= '0;
		end else if (clear) begin
			do_disc_a <= '0;
			do_disc_b <= '0;
			do_disc_c <= '0;
		end else begin
			do_disc_a <= do_disc_a | cmp_a | pol_a;
			do_disc_b <= do_disc_b | cmp_b | pol_b;
			do_disc_c <= do_disc_c | cmp_c | pol_c;
		end
	end

	assign do_fault_contact = do_disc_a | do_disc_b | do_disc_c;

	// incomplete-check message names the block's location
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			inc_valid    <= 1'b0;
			inc_rack     <= 8'h00;
			inc_slot     <= 8'h00;
			inc_position <= 5'h00;
		end else begin
			inc_valid <= give_up;
			if (give_up) begin
				inc_rack     <= block_rack;
				inc_slot     <= block_slot;
				inc_position <= serial_bus_position;
			end
		end
	end
	// ---------------- fault log events ----------------
	// one event per cycle; simultaneous new faults of lower
	// priority are still latched but share the single entry
	wire [NDI-1:0] di_all = di_disc_a | di_disc_b | di_disc_c;
	wire [NDO-1:0] do_all = do_fault_contact;
	logic [NDI-1:0] di_prev;
	logic [NDO-1:0] do_prev;
	logic [2:0]     ai_prev;

	wire new_di = |(di_all & ~di_prev);
	wire new_do = |(do_all & ~do_prev);
	wire new_ai = |(ai_disc & ~ai_prev);
	wire [7:0] code_sel = new_di ? CODE_DI_DISC
		: new_do ? CODE_DO_DISC : CODE_AI_DISC;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			di_prev   <= '0;
			do_prev   <= '0;
			ai_prev   <= 3'h0;
			log_valid <= 1'b0;
			log_code  <= 8'h00;
		end else begin
			di_prev   <= di_all;
			do_prev   <= do_all;
			ai_prev   <= ai_disc;
			log_valid <= new_di || new_do || new_ai;
			if (new_di || new_do || new_ai)
				log_code <= code_sel;
		end
	end

	// ---------------- tristate classification ----------------
	wire [31:0] v_s    = 32'(tri_mv) * PCT_SCALE;
	wire [31:0] src_lo = SRC_OFF_PCT * 32'(supply_mv);
	wire [31:0] snk_hi = SNK_OFF_PCT * 32'(supply_mv);
	wire [31:0] v32    = 32'(tri_mv);
	wire [31:0] top    = 32'(supply_mv);
	wire src_off   = v_s < src_lo;
	wire src_short = v32 + SHORT_MV > top;
	wire snk_short = v32 < SHORT_MV;
	wire snk_off   = v_s > snk_hi;
	wire t_short   = tri_sink ? snk_short : (src_short && !src_off);
	wire t_off     = tri_sink ? (snk_off && !snk_short) : src_off;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tri_value <= 1'b0;
			tri_on    <= 1'b0;
			tri_short <= 1'b0;
		end else if (scan_pulse) begin
			tri_short <= t_short;
			tri_on    <= !t_short && !t_off;
			tri_value <= !t_off;
		end
	end

endmodule : tdm_monitor

/* verilog/tdm_pkg.sv */
// shared constants for the redundant-channel discrepancy monitor
package tdm_pkg;

	// fault description codes
	localparam logic [7:0] CODE_DI_DISC   = 8'hf1;
	localparam logic [7:0] CODE_DO_DISC   = 8'hf3;
	localparam logic [7:0] CODE_AI_DISC   = 8'hf4;

	// output check attempts and scan window
	localparam logic [1:0] MAX_ATTEMPTS   = 2'h3;
	localparam logic [3:0] CHECK_SCANS    = 4'ha;

	// reset values
	localparam logic [7:0] FILT_CNT_RST   = 8'h00;
	localparam logic [3:0] WIN_CNT_RST    = 4'h0;
	localparam logic [1:0] ATTEMPT_RST    = 2'h1;

	// percentage arithmetic, voltages in millivolts
	localparam logic [31:0] PCT_SCALE     = 32'h0000_0064;
	localparam logic [31:0] SRC_OFF_PCT   = 32'h0000_001e;
	localparam logic [31:0] SNK_OFF_PCT   = 32'h0000_0046;
	localparam logic [31:0] SHORT_MV      = 32'h0000_0fa0;

	// output check sequence, gray coded
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_POLL = 2'b01,
		ST_RUN  = 2'b11,
		ST_DONE = 2'b10
	} tdm_state_type;

endpackage : tdm_pkg

/* verilog/tdm_filter.sv */
// persistence filter and fault latch for one discrepancy channel
module tdm_filter
	import tdm_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// scan timing and fault reset
	input  wire logic       scan_pulse,
	input  wire logic       clear,
	input  wire logic [7:0] filter_scans,
	// raw mismatch and latched fault
	input  wire logic       raw,
	output logic            latched
);

	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic       latched_next;
	wire        persisted;

	// persisted once the mismatch has lasted the filter time
	assign persisted = raw && (cnt_reg >= filter_scans);

	// count consecutive scans with the mismatch present
	always_comb begin
		cnt_next = cnt_reg;
		if (scan_pulse) begin
			if (!raw)
				cnt_next = FILT_CNT_RST;
			else if (cnt_reg != 8'hff)
				cnt_next = cnt_reg + 8'h01;
		end
	end

	// clear beats a same-cycle detection; the counter keeps its
	// value so the still-present fault latches at the next scan
	always_comb begin
		latched_next = latched;
		if (clear)
			latched_next = 1'b0;
		else if (scan_pulse && persisted)
			latched_next = 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= FILT_CNT_RST;
			latched <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			latched <= latched_next;
		end
	end

endmodule : tdm_filter

/* bench/tdm_monitor_properties.sv */
// port assertions for the discrepancy monitor
module tdm_monitor_properties #(
	parameter int NDI = 8,
	parameter int NDO = 8,
	parameter int AW  = 16
) (
	// clock, reset and scan control
	input wire logic           clk,
	input wire logic           rst_n,
	input wire logic           scan_pulse,
	input wire logic           fault_reset_req,
	// discrete input side
	input wire logic [NDI-1:0] din_a,
	input wire logic [NDI-1:0] din_b,
	input wire logic [NDI-1:0] din_c,
	input wire logic [NDI-1:0] voted_din,
	input wire logic [NDI-1:0] di_disc_a,
	input wire logic [NDI-1:0] di_disc_b,
	input wire logic [NDI-1:0] di_disc_c,
	input wire logic [NDI-1:0] di_fault_contact,
	// analog flags and fault log
	input wire logic [2:0]     ai_disc,
	input wire logic           log_valid,
	input wire logic [7:0]     log_code,
	// output check start and poll
	input wire logic           autotest_busy,
	input wire logic           block_redundant,
	input wire logic           block_check_en,
	input wire logic           poll_req,
	input wire logic           poll_ack
);
	import tdm_pkg::*;
	logic [NDI-1:0] maj;
	// majority recomputed here so a wrong vote cannot hide
	assign maj = (din_a & din_b) | (din_a & din_c) | (din_b & din_c);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// poll steps: waiting for the block, then its answer
	sequence s_poll_wait;
		poll_req && !poll_ack;
	endsequence
	sequence s_poll_answer;
		poll_req && poll_ack;
	endsequence
	property p_vote;
		scan_pulse |=> voted_din == $past(maj);
	endproperty
	a_vote: assert property (p_vote) else $error("bad vote");
	property p_contact;
		di_fault_contact == (di_disc_a | di_disc_b | di_disc_c);
	endproperty
	a_contact: assert property (p_contact) else $error("bad contact");
	property p_clear;
		scan_pulse && fault_reset_req |=> di_fault_contact == '0 && ai_disc == 3'h0;
	endproperty
	a_clear: assert property (p_clear) else $error("no clear");
	// without a clear, a latched flag never falls
	property p_latch;
		!(scan_pulse && fault_reset_req) |=>
			(di_fault_contact & $past(di_fault_contact)) == $past(di_fault_contact)
			&& (ai_disc & $past(ai_disc)) == $past(ai_disc);
	endproperty
	a_latch: assert property (p_latch) else $error("flag fell");
	property p_log_f1;
		|(di_fault_contact & ~$past(di_fault_contact)) |=>
			log_valid && log_code == CODE_DI_DISC;
	endproperty
	a_log_f1: assert property (p_log_f1) else $error("no input log");
	property p_ai_two;
		ai_disc != 3'h7;
	endproperty
	a_ai_two: assert property (p_ai_two) else $error("three flagged");
	property p_poll_hold;
		s_poll_wait |=> poll_req;
	endproperty
	a_poll_hold: assert property (p_poll_hold) else $error("poll drop");
	property p_poll_end;
		s_poll_answer |=> !poll_req;
	endproperty
	a_poll_end: assert property (p_poll_end) else $error("poll stays");
	property p_poll_start;
		$rose(poll_req) |-> $past(scan_pulse && !autotest_busy
			&& (block_redundant || block_check_en));
	endproperty
	a_poll_start: assert property (p_poll_start) else $error("bad start");
endmodule : tdm_monitor_properties

bind tdm_monitor tdm_monitor_properties #(
	.NDI(NDI),
	.NDO(NDO),
	.AW (AW)
) i_props (
	.clk, .rst_n, .scan_pulse, .fault_reset_req, .din_a, .din_b, .din_c,
	.voted_din, .di_disc_a, .di_disc_b, .di_disc_c, .di_fault_contact,
	.ai_disc, .log_valid, .log_code, .autotest_busy, .block_redundant,
	.block_check_en, .poll_req, .poll_ack
);

/* bench/tdm_io_model.sv */
// output block answering the monitor's discrepancy polls
module tdm_io_model (
	// clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// poll handshake
	input wire logic       poll_req,
	output logic           poll_ack,
	output logic           poll_disc,
	output logic [2:0]     poll_output,
	output logic [1:0]     poll_ctl,
	// answer chosen by the bench: wait, then {disc, output, ctl}
	input wire logic [3:0] delay,
	input wire logic [5:0] answer
);
	logic [3:0] wait_reg;
	logic [5:0] fields_reg;
	assign {poll_disc, poll_output, poll_ctl} = fields_reg;
	// fields invert outside the ack cycle so stale data never passes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_reg <= 4'h0;
			poll_ack <= 1'b0;
			fields_reg <= 6'h00;
		end else if (poll_req && !poll_ack && wait_reg == delay) begin
			wait_reg <= 4'h0;
			poll_ack <= 1'b1;
			fields_reg <= answer;
		end else begin
			wait_reg <= (poll_req && !poll_ack) ? wait_reg + 4'h1 : 4'h0;
			poll_ack <= 1'b0;
			fields_reg <= ~fields_reg;
		end
	end
endmodule : tdm_io_model

/* bench/tdm_monitor_test.sv */
// self-checking bench for the discrepancy monitor
module tdm_monitor_test;
	timeunit 1ns;
	timeprecision 1ns;
	import tdm_pkg::*;
	logic        clk, rst_n, scan_pulse, fault_reset_req, v;
	logic        autotest_busy, block_redundant, block_check_en, tri_sink;
	logic        poll_req, poll_ack, poll_disc, inc_valid, log_valid;
	logic        ai_fault_contact, tri_value, tri_on, tri_short;
	logic [1:0]  poll_ctl;
	logic [2:0]  ai_disc, poll_output;
	logic [3:0]  m_delay;
	logic [4:0]  serial_bus_position, inc_position;
	logic [5:0]  m_ans;
	logic [6:0]  thresh_pct, limit_pct;
	logic [7:0]  filter_scans, din_a, din_b, din_c, voted_din, di_fault_contact;
	logic [7:0]  di_disc_a, di_disc_b, di_disc_c, block_rack, block_slot;
	logic [7:0]  ctl_out_a, ctl_out_b, ctl_out_c, voted_dout, do_fault_contact;
	logic [7:0]  do_disc_a, do_disc_b, do_disc_c, inc_rack, inc_slot, log_code;
	logic [7:0]  last_code;
	logic [15:0] ain_a, ain_b, ain_c, full_scale, voted_ain, tri_mv, supply_mv;
	int          error_cnt, total_checks, k;
	int          inc_seen = 0;

	tdm_monitor i_dut (
		.clk, .rst_n, .scan_pulse, .fault_reset_req, .filter_scans, .din_a,
		.din_b, .din_c, .voted_din, .di_disc_a, .di_disc_b, .di_disc_c,
		.di_fault_contact, .ain_a, .ain_b, .ain_c, .thresh_pct, .limit_pct,
		.full_scale, .voted_ain, .ai_disc, .ai_fault_contact, .autotest_busy,
		.block_redundant, .block_check_en, .block_rack, .block_slot,
		.serial_bus_position, .ctl_out_a, .ctl_out_b, .ctl_out_c, .voted_dout,
		.poll_req, .poll_ack, .poll_disc, .poll_output, .poll_ctl, .do_disc_a,
		.do_disc_b, .do_disc_c, .do_fault_contact, .inc_valid, .inc_rack,
		.inc_slot, .inc_position, .log_valid, .log_code, .tri_sink, .tri_mv,
		.supply_mv, .tri_value, .tri_on, .tri_short
	);
	tdm_io_model i_blk (
		.clk, .rst_n, .poll_req, .poll_ack, .poll_disc, .poll_output,
		.poll_ctl, .delay(m_delay), .answer(m_ans)
	);

	// clock at 10 MHz
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// pulses and log codes are caught on the edge they stand
	always @(posedge clk) begin
		if (inc_valid === 1'b1) inc_seen <= inc_seen + 1;
		if (log_valid === 1'b1) last_code <= log_code;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic scan(input int n);
		repeat (n) begin
			@(negedge clk) scan_pulse = 1'b1;
			@(negedge clk) scan_pulse = 1'b0;
		end
		repeat (2) @(negedge clk);
	endtask : scan
	task automatic clr;
		fault_reset_req = 1'b1;
		scan(1);
		fault_reset_req = 1'b0;
	endtask : clr
	// bounded wait: a hung poll shows up in the checks that follow
	task automatic wait_poll;
		for (int w = 0; w < 40 && poll_req !== 1'b0; w++) @(negedge clk);
	endtask : wait_poll
	task automatic an(input logic [15:0] a, b, c, fs);
		{ain_a, ain_b, ain_c, full_scale} = {a, b, c, fs};
		scan(1);
	endtask : an
	task automatic tri_case(input logic s, logic [15:0] mv, logic [2:0] e);
		{tri_sink, tri_mv} = {s, mv};
		scan(1);
		chk({tri_value, tri_on, tri_short}, e);
	endtask : tri_case
	task automatic final_report;
		if (error_cnt == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report

	// watchdog: the whole sequence needs well under a millisecond
	initial begin
		#1000000;
		error_cnt++;
		final_report();
	end

	initial begin
		{rst_n, error_cnt, total_checks} = '0;
		{scan_pulse, fault_reset_req, autotest_busy, block_check_en} = '0;
		{din_a, din_b, din_c, ctl_out_a, ctl_out_b, ctl_out_c} = '0;
		{ain_a, ain_b, ain_c, full_scale, tri_mv, tri_sink} = '0;
		{voted_dout, filter_scans, thresh_pct, limit_pct} = '0;
		{block_redundant, m_delay, m_ans, supply_mv} = {11'h000, 16'h5dc0};
		{block_rack, block_slot, serial_bus_position} = {8'h12, 8'h05, 5'h09};
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		// every pattern of the three copies, cleared after each
		for (k = 0; k < 8; k++) begin
			{din_a, din_b, din_c} = {{8{k[2]}}, {8{k[1]}}, {8{k[0]}}};
			scan(1);
			v = (k[2] & k[1]) | (k[2] & k[0]) | (k[1] & k[0]);
			chk(voted_din, {8{v}});
			chk({di_disc_a[0], di_disc_b[0], di_disc_c[0]}, {k[2] ^ v, k[1] ^ v, k[0] ^ v});
			chk(di_fault_contact, {8{k != 0 && k != 7}});
			if (k == 1) chk(last_code, CODE_DI_DISC);
			{din_a, din_b, din_c} = '0;
			clr();
		end
		// filter of two scans: flag needs three mismatching scans
		filter_scans = 8'h02;
		din_c = 8'h01;
		scan(2);
		chk(di_disc_c, 8'h00);
		scan(1);
		chk(di_disc_c, 8'h01);
		clr();
		chk(di_disc_c, 8'h00);
		scan(1);
		chk(di_disc_c, 8'h01);
		din_c = 8'h00;
		scan(1);
		chk(di_disc_c, 8'h01);
		clr();
		chk(di_disc_c, 8'h00);
		filter_scans = 8'h00;
		// analog: threshold alone, both bands, then two channels
		{thresh_pct, limit_pct} = {7'h0a, 7'h0a};
		an(16'h0009, 16'h000a, 16'h000f, 16'h00c8);
		chk(ai_disc, 3'h0);
		chk(voted_ain, 16'h000a);
		an(16'h005b, 16'h0064, 16'h006f, 16'h0032);
		chk(ai_disc, 3'h4);
		chk(ai_fault_contact, 1'b1);
		chk(last_code, CODE_AI_DISC);
		an(16'h0064, 16'h0064, 16'h0064, 16'h00c8);
		clr();
		an(16'h0096, 16'h0032, 16'h0064, 16'h00c8);
		chk(voted_ain, 16'h0064);
		chk(ai_disc, 3'h3);
		// tristate bands on both sides of each off boundary, short side of each short one
		tri_case(1'b0, 16'h1c1f, 3'h0);
		tri_case(1'b0, 16'h1c20, 3'h6);
		tri_case(1'b0, 16'h4e21, 3'h5);
		tri_case(1'b1, 16'h0f9f, 3'h5);
		tri_case(1'b1, 16'h41a0, 3'h6);
		tri_case(1'b1, 16'h41a1, 3'h0);
		// output check, slow answer naming output 2 of controller b
		{m_delay, m_ans, block_redundant} = {4'h4, 6'h29, 1'b1};
		{voted_dout, ctl_out_a, ctl_out_c} = {3{8'h0f}};
		ctl_out_b = 8'h0b;
		scan(1);
		wait_poll();
		scan(11);
		chk(do_disc_b, 8'h04);
		chk(do_disc_a | do_disc_c, 8'h00);
		chk(do_fault_contact, 8'h04);
		chk(last_code, CODE_DO_DISC);
		// outputs change at every scan: three attempts, then give up
		{m_delay, m_ans, ctl_out_b} = {4'h1, 6'h03, 8'h0f};
		wait_poll();
		clr();
		chk(do_fault_contact, 8'h00);
		for (k = 1; k < 4; k++) begin
			voted_dout = voted_dout ^ 8'h01;
			{ctl_out_a, ctl_out_b, ctl_out_c} = {3{voted_dout}};
			scan(1);
			wait_poll();
			chk(inc_seen, k == 3);
		end
		chk(do_fault_contact, 8'h00);
		chk({inc_rack, inc_slot}, 16'h1205);
		chk(inc_position, 5'h09);
		// no start under autotest or on a block left out of checking
		autotest_busy = 1'b1;
		scan(1);
		chk(poll_req, 1'b0);
		{autotest_busy, block_redundant} = 2'b00;
		scan(1);
		chk(poll_req, 1'b0);
		{block_check_en, m_delay} = {1'b1, 4'hf};
		scan(1);
		chk(poll_req, 1'b1);
		wait_poll();
		// autotest in the window aborts it: a mismatch must stay unlogged
		{autotest_busy, ctl_out_a} = {1'b1, ~voted_dout};
		scan(10);
		chk(do_fault_contact, 8'h00);
		// quick answer naming output 5 of controller c
		{autotest_busy, m_delay, m_ans} = {1'b0, 4'h0, 6'h36};
		scan(1);
		chk(do_disc_c, 8'h20);
		final_report();
	end
endmodule : tdm_monitor_test
